// [hdl/pgt_timer.sv]
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "pgt_cfg.svh"

// Operation
// RQ1 - run bit starts the timer; clearing it stops and holds the count
// RQ2 - with idle stop set, timer halts while device idle
// RQ3 - internal source with gate bit set gives gated accumulation
// RQ4 - external source ignores the gate bit
// RQ5 - prescale 11/10/01/00 divide by 256/64/8/1
// RQ6 - source bit one counts external rising edges, zero internal half clock
// RQ7 - wide mode chains both timers under low control only
// RQ8 - software routes external clock pin before selecting it
// RQ9 - unimplemented control bits ignore writes and read zero
// RQ10 - count increments per tick, wraps; low carry advances high in wide mode
// RQ11 - gated mode counts only while gate input high
module pgt_timer
  import pgt_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic idle_i,
  input wire logic low_ext_clock_pin_i,
  input wire logic high_ext_clock_pin_i,
  input wire logic low_gate_i,
  input wire logic high_gate_i,
  output logic [15:0] low_count_o,
  output logic [15:0] high_count_o
);
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] low_ctrl_q;
  logic [15:0] high_ctrl_q;
  logic [15:0] low_cnt_q;
  logic [15:0] high_cnt_q;
  logic idle_s1_q;
  logic idle_s2_q;
  logic low_gate_s1_q;
  logic low_gate_s2_q;
  logic high_gate_s1_q;
  logic high_gate_s2_q;
  logic wide;
  logic [15:0] high_eff_ctrl;
  logic low_tick;
  logic high_tick;
  logic high_adv;
  logic acc;
  logic wr_en;
  logic [15:0] wr_half;
  logic addr_ok;
  logic [31:0] rd_data;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_s1_q <= 1'b0;
      idle_s2_q <= 1'b0;
      low_gate_s1_q <= 1'b0;
      low_gate_s2_q <= 1'b0;
      high_gate_s1_q <= 1'b0;
      high_gate_s2_q <= 1'b0;
    end else begin
      idle_s1_q <= idle_i;
      idle_s2_q <= idle_s1_q;
      low_gate_s1_q <= low_gate_i;
      low_gate_s2_q <= low_gate_s1_q;
      high_gate_s1_q <= high_gate_i;
      high_gate_s2_q <= high_gate_s1_q;
    end
  end

  // ****************************************
  // apb slave, zero wait states
  // ****************************************
  assign acc = psel_i && penable_i;
  assign wr_en = acc && pwrite_i && addr_ok;
  assign wr_half = {(pstrb_i[1] ? pwdata_i[15:8] : 8'h00), (pstrb_i[0] ? pwdata_i[7:0] : 8'h00)};

  // address decode and read mux
  always_comb begin
    addr_ok = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (paddr_i)
      `PGT_LOW_CTRL_OFF: rd_data = {16'h0000, low_ctrl_q}; // [RQ9]
      `PGT_HIGH_CTRL_OFF: rd_data = {16'h0000, high_ctrl_q}; // [RQ9]
      `PGT_LOW_CNT_OFF: rd_data = {16'h0000, low_cnt_q};
      `PGT_HIGH_CNT_OFF: rd_data = {16'h0000, high_cnt_q};
      default: addr_ok = 1'b0;
    endcase
  end

  // bus answer registers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !addr_ok;
      prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rd_data : 32'h0000_0000;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // writes mask unimplemented bits to zero
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_ctrl_q <= `PGT_CTRL_RESET;
      high_ctrl_q <= `PGT_CTRL_RESET;
    end else if (wr_en && pready_o) begin
      if (paddr_i == `PGT_LOW_CTRL_OFF) begin
        low_ctrl_q <= wr_half & `PGT_LOW_MASK; // [RQ9]
      end
      if (paddr_i == `PGT_HIGH_CTRL_OFF) begin
        high_ctrl_q <= wr_half & `PGT_HIGH_MASK; // [RQ9]
      end
    end
  end

  // ****************************************
  // tick generation
  // ****************************************
  assign wide = low_ctrl_q[`PGT_WIDE_BIT];
  // wide mode hands the high half the low control
  assign high_eff_ctrl = wide ? low_ctrl_q : high_ctrl_q; // [RQ7]

  pgt_tick_gen u_low_tick (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .run_i(low_ctrl_q[`PGT_RUN_BIT]),
    .idle_stop_i(low_ctrl_q[`PGT_IDLE_STOP_BIT]),
    .idle_i(idle_s2_q),
    .gate_en_i(low_ctrl_q[`PGT_GATE_BIT]),
    .ext_sel_i(low_ctrl_q[`PGT_CS_BIT]), // [RQ8]
    .prescale_i(low_ctrl_q[`PGT_PS_HI_BIT:`PGT_PS_LO_BIT]),
    .ext_clk_i(low_ext_clock_pin_i),
    .gate_i(low_gate_s2_q),
    .tick_o(low_tick)
  );

  pgt_tick_gen u_high_tick (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .run_i(high_eff_ctrl[`PGT_RUN_BIT]),
    .idle_stop_i(high_eff_ctrl[`PGT_IDLE_STOP_BIT]),
    .idle_i(idle_s2_q),
    .gate_en_i(high_eff_ctrl[`PGT_GATE_BIT]),
    .ext_sel_i(high_eff_ctrl[`PGT_CS_BIT]),
    .prescale_i(high_eff_ctrl[`PGT_PS_HI_BIT:`PGT_PS_LO_BIT]),
    .ext_clk_i(high_ext_clock_pin_i),
    .gate_i(high_gate_s2_q),
    .tick_o(high_tick)
  );

  // high half advances on carry in wide mode
  assign high_adv = wide ? (low_tick && (low_cnt_q == 16'hFFFF)) : high_tick; // [RQ7] [RQ10]

  // ****************************************
  // counters, software writable
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_cnt_q <= `PGT_CNT_RESET;
    end else if (wr_en && pready_o && paddr_i == `PGT_LOW_CNT_OFF) begin
      low_cnt_q <= wr_half;
    end else if (low_tick) begin
      low_cnt_q <= low_cnt_q + 16'h0001; // [RQ10] [RQ1]
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      high_cnt_q <= `PGT_CNT_RESET;
    end else if (wr_en && pready_o && paddr_i == `PGT_HIGH_CNT_OFF) begin
      high_cnt_q <= wr_half;
    end else if (high_adv) begin
      high_cnt_q <= high_cnt_q + 16'h0001; // [RQ10]
    end
  end

  // registered count outputs
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_count_o <= `PGT_CNT_RESET;
      high_count_o <= `PGT_CNT_RESET;
    end else begin
      low_count_o <= low_cnt_q;
      high_count_o <= high_cnt_q;
    end
  end
endmodule

// [hdl/pgt_cfg.svh]
`ifndef PGT_CFG_SVH
`define PGT_CFG_SVH
// register byte offsets
`define PGT_LOW_CTRL_OFF 12'h000
`define PGT_HIGH_CTRL_OFF 12'h004
`define PGT_LOW_CNT_OFF 12'h008
`define PGT_HIGH_CNT_OFF 12'h00C
// control field positions
`define PGT_RUN_BIT 15
`define PGT_IDLE_STOP_BIT 13
`define PGT_GATE_BIT 6
`define PGT_PS_HI_BIT 5
`define PGT_PS_LO_BIT 4
`define PGT_WIDE_BIT 3
`define PGT_CS_BIT 1
// writable masks, unimplemented bits read zero
`define PGT_LOW_MASK 16'hA07A
`define PGT_HIGH_MASK 16'hA072
`define PGT_CTRL_RESET 16'h0000
`define PGT_CNT_RESET 16'h0000
// prescale terminal counts (divide minus one)
`define PGT_DIV1_TC 8'h00
`define PGT_DIV8_TC 8'h07
`define PGT_DIV64_TC 8'h3F
`define PGT_DIV256_TC 8'hFF
`endif

// [hdl/pgt_pkg.sv]
package pgt_pkg;
  typedef enum logic [1:0] {
    PGT_PS_1 = 2'b00,
    PGT_PS_8 = 2'b01,
    PGT_PS_64 = 2'b10,
    PGT_PS_256 = 2'b11
  } pgt_prescale_t;
endpackage

// [hdl/pgt_tick_gen.sv]
`timescale 1ns/10ps
`include "pgt_cfg.svh"
// ****************************************
// one timer's clock source, gate and prescaler
// ****************************************
module pgt_tick_gen
  import pgt_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic idle_stop_i,
  input wire logic idle_i,
  input wire logic gate_en_i,
  input wire logic ext_sel_i,
  input wire logic [1:0] prescale_i,
  input wire logic ext_clk_i,
  input wire logic gate_i,
  output logic tick_o
);
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic [7:0] ps_cnt_q;
  logic [7:0] ps_tc;
  logic int_half_q;
  logic src_tick;
  logic active;
  pgt_prescale_t ps_sel;

  // two-stage synchroniser, third stage for edge detect
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // internal instruction clock at half the device clock
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_half_q <= 1'b0;
    end else begin
      int_half_q <= ~int_half_q;
    end
  end

  // stop when off, or idle with stop-in-idle set
  assign active = run_i && !(idle_stop_i && idle_i); // [RQ1] [RQ2]

  // source select; gate only applies to the internal source
  always_comb begin
    if (ext_sel_i) begin
      src_tick = ext_s2_q && !ext_s3_q; // [RQ6] [RQ4]
    end else begin
      src_tick = int_half_q && (!gate_en_i || gate_i); // [RQ6] [RQ3] [RQ11]
    end
  end

  // prescale terminal count
  assign ps_sel = pgt_prescale_t'(prescale_i);
  always_comb begin
    unique case (ps_sel)
      PGT_PS_1: ps_tc = `PGT_DIV1_TC; // [RQ5]
      PGT_PS_8: ps_tc = `PGT_DIV8_TC; // [RQ5]
      PGT_PS_64: ps_tc = `PGT_DIV64_TC; // [RQ5]
      PGT_PS_256: ps_tc = `PGT_DIV256_TC; // [RQ5]
    endcase
  end

  // prescaler counter, cleared while stopped
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ps_cnt_q <= 8'h00;
      tick_o <= 1'b0;
    end else if (!active) begin
      ps_cnt_q <= 8'h00;
      tick_o <= 1'b0;
    end else if (src_tick) begin
      if (ps_cnt_q >= ps_tc) begin
        ps_cnt_q <= 8'h00;
        tick_o <= 1'b1; // [RQ5]
      end else begin
        ps_cnt_q <= ps_cnt_q + 8'h01;
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule

// [tb/pgt_timer_asserts.sv]
`timescale 1ns/10ps
// ***
// bus and counter checks
// ***
module pgt_timer_asserts(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [15:0] low_count_o,
  input wire logic [15:0] high_count_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic wr;
  // write access in flight
  assign wr = psel_i && penable_i && pwrite_i;
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  a_ready_has_setup: assert property (pready_o |-> $past(psel_i && !penable_i))
    else $error("ready without setup");
  a_err_unmapped: assert property (pready_o |-> pslverr_o == (paddr_i > 12'h00C || paddr_i[1:0] != 2'b00))
    else $error("bad error flag");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside access");
  a_low_mask: assert property (pready_o && !pwrite_i && paddr_i == 12'h000 |->
    (prdata_o & 32'hFFFF_5F85) == 32'h0000_0000) else $error("low control stray bits");
  a_high_mask: assert property (pready_o && !pwrite_i && paddr_i == 12'h004 |->
    (prdata_o & 32'hFFFF_5F8D) == 32'h0000_0000) else $error("high control stray bits");
  a_low_step: assert property ($changed(low_count_o) |-> low_count_o == $past(low_count_o) + 16'h0001
    || $past(wr) || $past(wr, 2) || $past(wr, 3)) else $error("low count jumped");
  a_high_step: assert property ($changed(high_count_o) |-> high_count_o == $past(high_count_o) + 16'h0001
    || $past(wr) || $past(wr, 2) || $past(wr, 3)) else $error("high count jumped");
  c_err: cover property (pslverr_o);
  c_write: cover property (wr && pready_o);
  c_high_moves: cover property (high_count_o != 16'h0000);
endmodule

// [tb/pgt_pin_model.sv]
`timescale 1ns/10ps
// ***
// pin source: clock bursts and gate level
// ***
module pgt_pin_model(
  input wire logic mclk_i,
  output logic clk_o,
  output logic gate_o
);
  initial begin
    clk_o = 1'b0;
    gate_o = 1'b0;
  end
  // gate level, set right after a clock edge
  task level(input logic v);
    gate_o <= v;
  endtask
  // routed pin, rising edges only in bursts, low between them
  task pulses(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      clk_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      clk_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
    end
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
// ***
// bench for the paired timer
// ***
module tb;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic idle = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] rd, cnt, prdata;
  logic err, pready, perr, lclk, lg, hclk, hg;
  logic [15:0] lc, hc;
  int bad_count = 0;
  int n_compared = 0;
  int dv[4] = '{1, 8, 64, 256};
  initial forever #2 mclk_i = ~mclk_i;
  pgt_timer uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .idle_i(idle), .low_ext_clock_pin_i(lclk),
    .high_ext_clock_pin_i(hclk), .low_gate_i(lg), .high_gate_i(hg), .low_count_o(lc),
    .high_count_o(hc));
  pgt_pin_model lp (.mclk_i(mclk_i), .clk_o(lclk), .gate_o(lg));
  pgt_pin_model hp (.mclk_i(mclk_i), .clk_o(hclk), .gate_o(hg));
  // one apb transfer, held until ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge mclk_i);
    pen <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task chk_rng(input logic [31:0] g, input int lo, input int hi);
    n_compared++;
    if ($isunknown(g) || g < lo || g > hi) begin
      bad_count++;
      $display("[ERR] %0t count %h out of range", $time, g);
    end
  endtask
  // clear count, then start with control c
  task go(input logic [11:0] a, input logic [15:0] c);
    apb(1'b1, a + 12'h008, 32'h0000_0000);
    apb(1'b1, a, {16'h0000, c});
  endtask
  // stop, read count, see it hold
  task stop(input logic [11:0] a);
    apb(1'b1, a, 32'h0000_0000);
    apb(1'b0, a + 12'h008, 32'h0000_0000);
    cnt = rd;
    repeat (10) @(posedge mclk_i);
    apb(1'b0, a + 12'h008, 32'h0000_0000);
    chk(rd, cnt);
    chk({16'h0000, (a == 12'h000) ? lc : hc}, cnt);
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    apb(1'b1, 12'h000, 32'hFFFF_7FFF);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_207A);
    apb(1'b1, 12'h004, 32'hFFFF_7FFF);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_2072);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_0000);
    $display("registers done");
    for (int p = 0; p < 4; p++) begin
      go(12'h000, {4'h8, 6'h00, p[1:0], 4'h0});
      repeat (32 * dv[p] - 2) @(posedge mclk_i);
      stop(12'h000);
      chk_rng(cnt, 15, 17);
    end
    $display("prescale done");
    apb(1'b1, 12'h008, 32'h0000_FFFE);
    apb(1'b1, 12'h00C, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_8008);
    apb(1'b1, 12'h004, 32'h0000_8000);
    repeat (20) @(posedge mclk_i);
    apb(1'b1, 12'h004, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    chk({16'h0000, hc}, 32'h0000_0001);
    $display("wide done");
    go(12'h000, 16'h8040);
    repeat (100) @(posedge mclk_i);
    stop(12'h000);
    chk(cnt, 32'h0000_0000);
    lp.level(1'b1);
    go(12'h000, 16'h8040);
    repeat (100) @(posedge mclk_i);
    stop(12'h000);
    chk_rng(cnt, 45, 53);
    lp.level(1'b0);
    $display("gate done");
    go(12'h000, 16'h8042);
    go(12'h004, 16'h8042);
    fork
      lp.pulses(5);
      hp.pulses(7);
    join
    repeat (8) @(posedge mclk_i);
    stop(12'h000);
    chk(cnt, 32'h0000_0005);
    stop(12'h004);
    chk(cnt, 32'h0000_0007);
    $display("external done");
    idle <= 1'b1;
    hp.level(1'b1);
    go(12'h004, 16'hA040);
    repeat (100) @(posedge mclk_i);
    stop(12'h004);
    chk(cnt, 32'h0000_0000);
    go(12'h004, 16'h8040);
    repeat (100) @(posedge mclk_i);
    stop(12'h004);
    chk_rng(cnt, 45, 53);
    $display("idle done");
    test_done;
  end
endmodule
bind pgt_timer pgt_timer_asserts chk_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .low_count_o(low_count_o), .high_count_o(high_count_o));
